// File: verilog/flash_seq_map.svh
// Offsets, field positions, keys and timing for the flash row write sequencer
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define OFS_ADDR_LOW 3'h0
`define OFS_ADDR_HIGH 3'h1
`define OFS_DATA_LOW 3'h2
`define OFS_DATA_HIGH 3'h3
`define OFS_CONTROL 3'h4
`define OFS_UNLOCK_KEY 3'h5
`define CTL_CONFIG_SELECT 6
`define CTL_LATCH_ONLY 5
`define CTL_FREE 4
`define CTL_WRERR 3
`define CTL_PROG_ENABLE 2
`define CTL_WR 1
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define LATCH_BLANK 14'h3fff
`define ROW_LSB 5
`define FORCED_NOPS 2'h2
`define PROG_TIME_NS 2000000
`define CLK_PERIOD_NS 20
`endif

// File: verilog/flash_seq_pkg.sv
// Types shared by the flash row write sequencer
package flash_seq_pkg;
	typedef logic [13:0] latch_word_t;
	typedef struct packed {
		logic [9:0] row;
		logic write;
		logic erase;
	} flash_cmd_t;
	typedef enum logic [1:0] {KEY_IDLE = 2'b01, KEY_GOT_FIRST = 2'b10} key_state_t;
	typedef enum logic [2:0] {SEQ_IDLE = 3'b001, SEQ_NOP = 3'b010, SEQ_BUSY = 3'b100} seq_state_t;
endpackage

// File: verilog/flash_row_write_latch_sequencer.sv
// Flash self-programming write path: unlock, write latches and row commit
`timescale 1ns/10ps
`include "flash_seq_map.svh"

// Notes on behaviour
// R01 - Upper ten bits pick row, low bits latch
// R02 - A commit never spans more than one row
// R03 - Every latch returns to 3FFF after completion
// R04 - Unloaded latches stay blank through a commit
// R05 - Programming never erases the target row
// R06 - At most sixteen latches per program operation
// R07 - Latch-only flag set: load latch, no programming
// R08 - Flag clear: load latch then program row
// R09 - Start needs 55h then AAh key writes
// R10 - Broken handshake: no load, no program
// R11 - Firmware sets enable, clears config select first
// R12 - Firmware loads words, unlocks, increments address
// R13 - Firmware clears flag for the final word
// R14 - Firmware programs only erased words
// R15 - Latch load forces two no-op cycles
// R16 - Commit stalls core after two no-ops
// R17 - Firmware merges row in memory before rewriting
// R18 - Start bit software-set, hardware-cleared at end
// R19 - Enable bit low refuses program and erase
// R20 - Core halts about 2 ms during program
// R21 - Sixteen 14-bit latch registers hold loaded words
module flash_row_write_latch_sequencer #(
	parameter int LATCHES = 16,
	parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output flash_seq_pkg::flash_cmd_t flash_cmd,
	output flash_seq_pkg::latch_word_t [LATCHES-1:0] latch_data,
	output logic cpu_force_nop,
	output logic cpu_stall
);
	import flash_seq_pkg::*;

	localparam int IDX_W = $clog2(LATCHES);
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	logic [7:0] addr_low_reg;
	logic [6:0] addr_high_reg;
	logic [7:0] data_low_reg;
	logic [5:0] data_high_reg;
	logic config_space_select_reg, latch_only_flag_reg, free_reg, wrerr_reg, program_enable_reg, wr_reg;
	logic [7:0] rdata_reg;
	key_state_t key_reg, key_next;
	logic armed_reg, armed_next;
	seq_state_t seq_reg;
	logic [1:0] nop_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic commit_reg;
	flash_cmd_t cmd_reg;
	latch_word_t [LATCHES-1:0] latch_reg;

	// Register decode
	wire wr_ctl = reg_wr && (reg_addr == `OFS_CONTROL);
	wire wr_key = reg_wr && (reg_addr == `OFS_UNLOCK_KEY);
	wire any_access = reg_wr || reg_rd;
	// Fields of the control byte being written; a start obeys these new values
	wire config_select_in = reg_wdata[`CTL_CONFIG_SELECT];
	wire latch_only_in = reg_wdata[`CTL_LATCH_ONLY];
	wire free_in = reg_wdata[`CTL_FREE];
	wire enable_in = reg_wdata[`CTL_PROG_ENABLE];
	wire set_attempt = wr_ctl && reg_wdata[`CTL_WR] && !wr_reg;
	wire seq_start = set_attempt && armed_reg && enable_in && !config_select_in; // [R09] [R19]
	wire refused = set_attempt && !seq_start; // [R10] [R19]
	wire load_latch = seq_start && !free_in; // [R07] [R08]
	wire commit_start = seq_start && (free_in || !latch_only_in); // [R08]
	wire [7:0] ctl_readback = {1'b1, config_space_select_reg, latch_only_flag_reg, free_reg,
		wrerr_reg, program_enable_reg, wr_reg, 1'b0};
	wire [IDX_W-1:0] latch_idx = addr_low_reg[IDX_W-1:0]; // [R01] [R06]
	wire [9:0] row_sel = {addr_high_reg, addr_low_reg[7:`ROW_LSB]}; // [R01] [R02]
	wire latch_word_t new_word = {data_high_reg, data_low_reg};
	wire nop_last = (seq_reg == SEQ_NOP) && (nop_reg == 2'h1);
	wire busy_done = (seq_reg == SEQ_BUSY) && (cnt_reg == '0);
	wire op_done = busy_done || (nop_last && !commit_reg);

	assign reg_rdata = rdata_reg;
	assign flash_cmd = cmd_reg;
	assign latch_data = latch_reg;
	assign cpu_force_nop = (seq_reg == SEQ_NOP); // [R15] [R16]
	assign cpu_stall = (seq_reg == SEQ_BUSY); // [R16] [R20]

	// Unlock handshake: any other access in between breaks it
	always_comb begin
		key_next = KEY_IDLE;
		armed_next = 1'b0;
		if (wr_key && reg_wdata == `KEY_FIRST) begin
			key_next = KEY_GOT_FIRST;
		end else if (wr_key && reg_wdata == `KEY_SECOND && key_reg == KEY_GOT_FIRST) begin
			armed_next = 1'b1; // [R09]
		end else if (!any_access) begin
			key_next = key_reg;
			armed_next = armed_reg;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			key_reg <= KEY_IDLE;
			armed_reg <= 1'b0;
		end else begin
			key_reg <= key_next; // [R10]
			armed_reg <= armed_next;
		end
	end

	// Address, data and read-back
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			addr_low_reg <= 8'h00;
			addr_high_reg <= 7'h00;
			data_low_reg <= 8'h00;
			data_high_reg <= 6'h00;
			rdata_reg <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `OFS_ADDR_LOW) addr_low_reg <= reg_wdata;
			if (reg_wr && reg_addr == `OFS_ADDR_HIGH) addr_high_reg <= reg_wdata[6:0];
			if (reg_wr && reg_addr == `OFS_DATA_LOW) data_low_reg <= reg_wdata;
			if (reg_wr && reg_addr == `OFS_DATA_HIGH) data_high_reg <= reg_wdata[5:0];
			if (reg_rd) begin
				case (reg_addr)
					`OFS_ADDR_LOW: rdata_reg <= addr_low_reg;
					`OFS_ADDR_HIGH: rdata_reg <= {1'b1, addr_high_reg};
					`OFS_DATA_LOW: rdata_reg <= data_low_reg;
					`OFS_DATA_HIGH: rdata_reg <= {2'b00, data_high_reg};
					`OFS_CONTROL: rdata_reg <= ctl_readback;
					default: rdata_reg <= 8'h00;
				endcase
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	// Control bits; hardware set of the error flag wins over a clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			config_space_select_reg <= 1'b0;
			latch_only_flag_reg <= 1'b0;
			free_reg <= 1'b0;
			wrerr_reg <= 1'b0;
			program_enable_reg <= 1'b0;
			wr_reg <= 1'b0;
		end else begin
			if (wr_ctl) begin
				config_space_select_reg <= config_select_in;
				latch_only_flag_reg <= latch_only_in;
				program_enable_reg <= enable_in;
				wrerr_reg <= reg_wdata[`CTL_WRERR];
			end
			if (refused) wrerr_reg <= 1'b1;
			if (busy_done && free_reg) begin
				free_reg <= 1'b0;
			end else if (wr_ctl) begin
				free_reg <= reg_wdata[`CTL_FREE];
			end
			if (seq_start) begin
				wr_reg <= 1'b1; // [R18]
			end else if (op_done) begin
				wr_reg <= 1'b0; // [R18]
			end
		end
	end

	// Sequencer: two forced no-ops, then self-timed commit or erase
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			seq_reg <= SEQ_IDLE;
			nop_reg <= 2'h0;
			cnt_reg <= '0;
			commit_reg <= 1'b0;
			cmd_reg <= '0;
		end else begin
			cmd_reg.write <= 1'b0;
			cmd_reg.erase <= 1'b0;
			case (seq_reg)
				SEQ_IDLE: begin
					if (seq_start) begin
						seq_reg <= SEQ_NOP;
						nop_reg <= `FORCED_NOPS; // [R15]
						commit_reg <= commit_start; // [R07] [R08]
					end
				end
				SEQ_NOP: begin
					nop_reg <= nop_reg - 2'h1;
					if (nop_last) begin
						if (commit_reg) begin
							seq_reg <= SEQ_BUSY; // [R16]
							cnt_reg <= CNT_W'(PROG_CYCLES - 1); // [R20]
							cmd_reg.row <= row_sel; // [R02]
							cmd_reg.write <= !free_reg; // [R05] [R08]
							cmd_reg.erase <= free_reg; // [R05]
						end else begin
							seq_reg <= SEQ_IDLE; // [R15]
						end
					end
				end
				SEQ_BUSY: begin
					cnt_reg <= cnt_reg - CNT_W'(1);
					if (busy_done) seq_reg <= SEQ_IDLE;
				end
				default: seq_reg <= SEQ_IDLE;
			endcase
		end
	end

	// Write latch bank
	genvar gi;
	generate
		for (gi = 0; gi < LATCHES; gi++) begin : g_latch
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					latch_reg[gi] <= `LATCH_BLANK;
				end else if (busy_done) begin
					latch_reg[gi] <= `LATCH_BLANK; // [R03] [R04]
				end else if (load_latch && latch_idx == IDX_W'(gi)) begin
					latch_reg[gi] <= new_word; // [R21]
				end
			end
		end
	endgenerate

	// Checks
	a_unlock_before_start: assert property (@(posedge clock) disable iff (!arst_n) // [R09]
		seq_start |-> $past(wr_key && reg_wdata == `KEY_SECOND) || !$past(any_access))
		else $error("start accepted without unlock");
	a_broken_key_refused: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
		(set_attempt && !armed_reg) |=> (seq_reg == SEQ_IDLE) && wrerr_reg)
		else $error("start accepted on broken unlock");
	a_latch_only_quiet: assert property (@(posedge clock) disable iff (!arst_n) // [R07]
		(load_latch && latch_only_in) |-> ##1 cpu_force_nop[*2] ##1 (!cpu_stall && !flash_cmd.write && !wr_reg))
		else $error("latch-only load started programming");
	a_commit_issues_row: assert property (@(posedge clock) disable iff (!arst_n) // [R08]
		(load_latch && !latch_only_in) |-> ##3 (flash_cmd.write && !flash_cmd.erase && cpu_stall))
		else $error("commit did not program the row");
	a_loaded_word_held: assert property (@(posedge clock) disable iff (!arst_n) // [R21]
		load_latch |=> latch_reg[$past(latch_idx)] == $past(new_word))
		else $error("latch did not take the data pair");
	a_blank_after_done: assert property (@(posedge clock) disable iff (!arst_n) // [R03]
		busy_done |=> (latch_reg[0] == `LATCH_BLANK) && (latch_reg[LATCHES-1] == `LATCH_BLANK))
		else $error("latches not blank after completion");
	a_wr_self_clear: assert property (@(posedge clock) disable iff (!arst_n) // [R18]
		$fell(wr_reg) |-> $past(op_done))
		else $error("start bit cleared outside completion");
	a_no_prog_disabled: assert property (@(posedge clock) disable iff (!arst_n) // [R19]
		(set_attempt && !enable_in) |=> !cpu_force_nop && !wr_reg)
		else $error("operation started with enable low");
	a_stall_length: assert property (@(posedge clock) disable iff (!arst_n) // [R20]
		$rose(cpu_stall) |-> (cnt_reg == CNT_W'(PROG_CYCLES - 1)) && $past(cpu_force_nop, 1) && $past(cpu_force_nop, 2))
		else $error("stall not preceded by two no-ops or bad length");

	a_row_held_busy: assert property (@(posedge clock) disable iff (!arst_n) // [R02]
		(cpu_stall && $past(cpu_stall)) |-> $stable(flash_cmd.row))
		else $error("row changed during a commit");
	a_row_from_addr: assert property (@(posedge clock) disable iff (!arst_n) // [R01]
		$rose(cpu_stall) |-> (flash_cmd.row == $past(row_sel)))
		else $error("commit row not taken from upper address bits");
	a_bank_blank_done: assert property (@(posedge clock) disable iff (!arst_n) // [R03]
		busy_done |=> (latch_data == {LATCHES{latch_word_t'(`LATCH_BLANK)}}))
		else $error("latch bank not fully blank after completion");
	a_latch_only_on_load: assert property (@(posedge clock) disable iff (!arst_n) // [R04]
		(!load_latch && !busy_done) |=> $stable(latch_data))
		else $error("latch changed without a load or completion");
	a_no_auto_erase: assert property (@(posedge clock) disable iff (!arst_n) // [R05]
		load_latch |-> ##3 !flash_cmd.erase)
		else $error("program start issued an erase");
	a_two_forced_nops: assert property (@(posedge clock) disable iff (!arst_n) // [R15]
		$rose(cpu_force_nop) |=> cpu_force_nop ##1 !cpu_force_nop)
		else $error("forced no-op window not two cycles");
	a_commit_stalls: assert property (@(posedge clock) disable iff (!arst_n) // [R16]
		commit_start |-> ##3 cpu_stall[*2])
		else $error("commit did not stall the core after the no-ops");
	a_key_broken: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
		(any_access && !wr_key) |=> !armed_reg)
		else $error("unlock survived an unrelated access");
	a_disabled_no_load: assert property (@(posedge clock) disable iff (!arst_n) // [R19]
		(set_attempt && !enable_in) |=> $stable(latch_data))
		else $error("latch loaded with enable low");
	a_wr_tracks_op: assert property (@(posedge clock) disable iff (!arst_n) // [R18]
		wr_reg |-> (cpu_force_nop || cpu_stall))
		else $error("start bit set with no operation running");

	// Length of the current stall, for the stall checks
	logic [CNT_W-1:0] stall_len_reg;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stall_len_reg <= '0;
		end else if (cpu_stall) begin
			stall_len_reg <= stall_len_reg + CNT_W'(1);
		end else begin
			stall_len_reg <= '0;
		end
	end

	a_stall_full_length: assert property (@(posedge clock) disable iff (!arst_n) // [R20]
		$fell(cpu_stall) |-> (stall_len_reg == CNT_W'(PROG_CYCLES)))
		else $error("stall length differs from the program time");
	a_stall_bounded: assert property (@(posedge clock) disable iff (!arst_n) // [R20]
		stall_len_reg <= CNT_W'(PROG_CYCLES))
		else $error("stall ran past the program time");

	c_latch_load: cover property (@(posedge clock) disable iff (!arst_n) load_latch && latch_only_in);
	c_stall_end: cover property (@(posedge clock) disable iff (!arst_n) $fell(cpu_stall));
	c_row_commit: cover property (@(posedge clock) disable iff (!arst_n) busy_done && !free_reg);
	c_row_erase: cover property (@(posedge clock) disable iff (!arst_n) flash_cmd.erase);
	c_broken_key: cover property (@(posedge clock) disable iff (!arst_n) refused);
endmodule

// File: bench/firmware_model.sv
// Firmware model driving the sequencer register port
`timescale 1ns/10ps
module firmware_model (
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic [2:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 3'h7;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge clock);
		d = reg_rdata;
	endtask
	// Key pair then start; a read between keys breaks it
	task automatic unlock(input logic [7:0] ctl, input bit brk);
		logic [7:0] d;
		wr(3'h5, 8'h55);
		if (brk) rd(3'h0, d);
		wr(3'h5, 8'haa);
		wr(3'h4, ctl);
	endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the flash row write sequencer
`timescale 1ns/10ps
module testbench;
	import flash_seq_pkg::*;
	localparam int PROG = 8;
	logic clock;
	logic arst_n;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	flash_cmd_t flash_cmd;
	latch_word_t [15:0] latch_data;
	logic cpu_force_nop;
	logic cpu_stall;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int lat[16];
	logic [7:0] al;
	logic [7:0] ah;
	logic [13:0] word;
	logic [7:0] rv;
	flash_row_write_latch_sequencer #(.LATCHES(16), .PROG_CYCLES(PROG)) DUT (.clock(clock), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.flash_cmd(flash_cmd), .latch_data(latch_data), .cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall));
	firmware_model fw (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic latches();
		for (int i = 0; i < 16; i++) begin
			chk(16'(latch_data[i]), 16'(lat[i]));
		end
	endtask
	// One start attempt, then force_nop, command pulse, stall and blanking
	task automatic op(input logic [7:0] ctl, input bit brk);
		bit ok;
		bit ers;
		bit prog;
		ok = !brk && ctl[1] && ctl[2] && !ctl[6];
		ers = ok && ctl[4];
		prog = ok && !ctl[4] && !ctl[5];
		word = 14'($urandom);
		fw.wr(3'h2, word[7:0]);
		fw.wr(3'h3, {2'h0, word[13:8]});
		fw.rd(3'h3, rv);
		chk(rv, {2'h0, word[13:8]});
		fw.unlock(ctl, brk);
		if (ok && !ers) lat[al[3:0]] = word;
		@(negedge clock);
		latches();
		repeat (2) begin
			chk(cpu_force_nop, ok);
			chk(flash_cmd.write, 0);
			@(negedge clock);
		end
		chk(cpu_force_nop, 0);
		chk(flash_cmd.write, prog);
		chk(flash_cmd.erase, ers);
		if (prog || ers) chk(flash_cmd.row, {ah[6:0], al[7:5]});
		repeat (PROG) begin
			chk(cpu_stall, prog || ers);
			@(negedge clock);
		end
		chk(cpu_stall, 0);
		if (prog || ers) lat = '{default: 16'h3fff};
		latches();
		fw.rd(3'h4, rv);
		chk(rv, {1'b1, ctl[6:5], ctl[4] && !ok, !ok, ctl[2], 2'b00});
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(21902));
		arst_n = 1'b0;
		lat = '{default: 16'h3fff};
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		latches();
		fw.rd(3'h4, rv);
		chk(rv, 8'h80);
		fw.rd(3'h6, rv);
		chk(rv, 8'h00);
		ah = {1'b0, 7'($urandom)};
		al = {3'($urandom), 5'h00};
		// Second round rewrites the same row: erase, then reload
		for (int r = 0; r < 2; r++) begin
			al[4:0] = 5'h00;
			fw.wr(3'h1, ah);
			fw.wr(3'h0, al);
			fw.rd(3'h1, rv);
			chk(rv, {1'b1, ah[6:0]});
			op(8'h16, 1'b0);
			fw.wr(3'h4, 8'h24);
			for (int i = 0; i < (r == 0 ? 15 : 2); i++) begin
				op(8'h26, 1'b0);
				al = al + 8'h01;
				fw.wr(3'h0, al);
			end
			op(8'h06, 1'b0);
		end
		op(8'h26, 1'b1);
		op(8'h22, 1'b0);
		op(8'h66, 1'b0);
		op(8'h26, 1'b0);
		op(8'h16, 1'b0);
		op(8'h26, 1'b0);
		// Reset in mid-run with a loaded latch
		@(posedge clock);
		arst_n <= 1'b0;
		lat = '{default: 16'h3fff};
		@(negedge clock);
		latches();
		chk(cpu_force_nop, 0);
		chk(cpu_stall, 0);
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		fw.rd(3'h4, rv);
		chk(rv, 8'h80);
		results();
	end
endmodule
